/* logic/adc_channel_gain_config_regs.sv */
// axi4-lite register bank for channel, rate, gain and chop configuration
`timescale 1ns/1ns
`default_nettype none

module adc_channel_gain_config_regs #(
  parameter int ADDR_W = 5
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // decoded settings for the converter core
  output adc_cfg_pkg::conv_ctrl_t conv_ctrl,
  // raw chop and current-detect word, decoded elsewhere
  output logic [15:0] chop_detect
);

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] chan_rate;
    logic [15:0] amp_gain;
    logic [15:0] spare;
    logic [15:0] chop_detect;
    logic spare_nz;
    adc_cfg_pkg::conv_ctrl_t ctrl;
  } state_t;

  state_t cur;
  state_t next_cur;

  // byte lanes 0 and 1 carry the 16-bit registers; upper lanes ignored
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb,
    input logic [15:0] wmask
  );
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~lanes) | (data[15:0] & lanes);
  endfunction

  function automatic logic [3:0] word_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] w;
    w = a[ADDR_W-1:2];
    word_index = 4'(w);
  endfunction

  // ratio doubles per code from 128; the top code is not a power of two
  function automatic logic [13:0] osr_ratio(input logic [2:0] code);
    if (code == 3'h7)
      osr_ratio = adc_cfg_pkg::OSR_TOP_RATIO;
    else
      osr_ratio = adc_cfg_pkg::OSR_BASE_RATIO << code;
  endfunction

  function automatic adc_cfg_pkg::power_mode_t pwr_mode(
    input logic [1:0] code
  );
    case (code)
      2'h0: pwr_mode = adc_cfg_pkg::PM_VERY_LOW;
      2'h1: pwr_mode = adc_cfg_pkg::PM_LOW;
      default: pwr_mode = adc_cfg_pkg::PM_HIGH_RES;
    endcase
  endfunction

  // gain is two to the power of the code
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    gain_of = 8'h01 << code;
  endfunction

  function automatic adc_cfg_pkg::conv_ctrl_t decode(
    input logic [15:0] chan_rate,
    input logic [15:0] amp_gain
  );
    adc_cfg_pkg::conv_ctrl_t c;
    c.channel_on = chan_rate[adc_cfg_pkg::CH_ON_LSB +: 4];
    c.oversampling_ratio =
      osr_ratio(chan_rate[adc_cfg_pkg::OSR_LSB +: 3]);
    c.power_mode = pwr_mode(chan_rate[adc_cfg_pkg::PWR_LSB +: 2]);
    for (int n = 0; n < adc_cfg_pkg::NUM_CH; n++)
    begin
      // ch3 14:12, ch2 10:8, ch1 6:4, ch0 2:0
      c.amp_gain[n] =
        gain_of(amp_gain[adc_cfg_pkg::GAIN_LSB_STEP*n +: 3]);
    end
    decode = c;
  endfunction

  logic take_aw;
  logic take_w;
  logic have_a;
  logic have_w;
  logic do_write;
  logic [3:0] w_idx;
  logic [31:0] w_dat;
  logic [3:0] w_stb;
  logic [15:0] spare_new;
  logic [3:0] r_idx;

  assign awready = !cur.aw_held && !cur.bvalid;
  assign wready = !cur.w_held && !cur.bvalid;
  assign arready = !cur.rvalid;

  always_comb
  begin
    next_cur = cur;
    take_aw = awvalid && awready;
    take_w = wvalid && wready;
    have_a = cur.aw_held || take_aw;
    have_w = cur.w_held || take_w;
    do_write = have_a && have_w && !cur.bvalid;
    w_idx = word_index(cur.aw_held ? cur.aw_addr : awaddr);
    w_dat = cur.w_held ? cur.w_data : wdata;
    w_stb = cur.w_held ? cur.w_strb : wstrb;
    spare_new = merge(cur.spare, w_dat, w_stb, adc_cfg_pkg::WMASK_FULL);
    r_idx = word_index(araddr);

    if (cur.bvalid && bready)
      next_cur.bvalid = 1'b0;
    if (take_aw)
    begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = awaddr;
    end
    if (take_w)
    begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = wdata;
      next_cur.w_strb = wstrb;
    end

    if (do_write)
    begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = adc_cfg_pkg::RESP_OKAY;
      case (w_idx)
        adc_cfg_pkg::IDX_CHAN_RATE:
          next_cur.chan_rate = merge(cur.chan_rate, w_dat, w_stb,
            adc_cfg_pkg::WMASK_CHAN_RATE);
        adc_cfg_pkg::IDX_AMP_GAIN:
          next_cur.amp_gain = merge(cur.amp_gain, w_dat, w_stb,
            adc_cfg_pkg::WMASK_FULL);
        adc_cfg_pkg::IDX_SPARE:
          next_cur.spare = spare_new;
        adc_cfg_pkg::IDX_CHOP_DETECT:
          next_cur.chop_detect = merge(cur.chop_detect, w_dat, w_stb,
            adc_cfg_pkg::WMASK_FULL);
        adc_cfg_pkg::IDX_STATUS:
        begin
          // write one to clear; a fresh set below still wins
          if (w_stb[0] && w_dat[adc_cfg_pkg::ST_SPARE_NZ])
            next_cur.spare_nz = 1'b0;
        end
        default:
          next_cur.bresp = adc_cfg_pkg::RESP_SLVERR;
      endcase
      // software owes zeros here; record any lapse for diagnosis
      if (w_idx == adc_cfg_pkg::IDX_SPARE && spare_new != 16'h0000)
        next_cur.spare_nz = 1'b1;
    end

    if (cur.rvalid && rready)
      next_cur.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = adc_cfg_pkg::RESP_OKAY;
      next_cur.rdata = 32'h0000_0000;
      case (r_idx)
        adc_cfg_pkg::IDX_CHAN_RATE:
          next_cur.rdata[15:0] = cur.chan_rate;
        adc_cfg_pkg::IDX_AMP_GAIN:
          next_cur.rdata[15:0] = cur.amp_gain;
        adc_cfg_pkg::IDX_SPARE:
          next_cur.rdata[15:0] = cur.spare;
        adc_cfg_pkg::IDX_CHOP_DETECT:
          next_cur.rdata[15:0] = cur.chop_detect;
        adc_cfg_pkg::IDX_STATUS:
          next_cur.rdata[adc_cfg_pkg::ST_SPARE_NZ] = cur.spare_nz;
        default:
          next_cur.rresp = adc_cfg_pkg::RESP_SLVERR;
      endcase
    end

    // settings are decoded from the next register values, so they change on the same edge as the registers
    next_cur.ctrl = decode(next_cur.chan_rate, next_cur.amp_gain);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur.aw_held <= 1'b0;
      cur.aw_addr <= '0;
      cur.w_held <= 1'b0;
      cur.w_data <= 32'h0000_0000;
      cur.w_strb <= 4'h0;
      cur.bvalid <= 1'b0;
      cur.bresp <= adc_cfg_pkg::RESP_OKAY;
      cur.rvalid <= 1'b0;
      cur.rdata <= 32'h0000_0000;
      cur.rresp <= adc_cfg_pkg::RESP_OKAY;
      cur.chan_rate <= adc_cfg_pkg::RST_CHAN_RATE;
      cur.amp_gain <=
        adc_cfg_pkg::RST_AMP_GAIN;
      cur.spare <= adc_cfg_pkg::RST_SPARE;
      cur.chop_detect <= adc_cfg_pkg::RST_CHOP_DETECT;
      cur.spare_nz <= 1'b0;
      cur.ctrl <= decode(adc_cfg_pkg::RST_CHAN_RATE,
        adc_cfg_pkg::RST_AMP_GAIN);
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign bvalid = cur.bvalid;
  assign bresp = cur.bresp;
  assign rvalid = cur.rvalid;
  assign rdata = cur.rdata;
  assign rresp = cur.rresp;
  assign conv_ctrl = cur.ctrl;
  assign chop_detect = cur.chop_detect;

endmodule

`default_nettype wire

/* common/adc_cfg_pkg.sv */
// constants and types for the converter configuration register bank
// What this block does
// - bits 11 to 8 of the channel config word enable channels 3 to 0, each resetting to one.
// - bits 4:2 pick the oversampling ratio 128 to 8192 in powers of two, code 7 gives 16256, reset 011b.
// - bits 1:0 pick the power mode, 00b very-low-power, 01b low-power, 1xb high-resolution, reset 10b.
// - bits 14:12 of the gain word hold channel 3's gain code, 1 to 128 in powers of two, reset 000b.
// - bits 10:8 of the gain word hold channel 2's gain code with that encoding, reset 000b.
// - bits 6:4 of the gain word hold channel 1's gain code with that encoding, reset 000b.
// - bits 2:0 of the gain word hold channel 0's gain code, code 110b meaning 64, reset 000b.
// - the gain word sits at index 4h and resets to all zeros, unity gain everywhere.
// - the spare word at index 5h resets to zero and software writes only zeros to it; the bank still stores a nonzero write and sets the status flag.
// - the chop and current-detect word sits at index 6h and resets to 0600h.
// - the channel config word sits at index 3h and resets to 0F0Eh.
package adc_cfg_pkg;

  // register indexes; byte address is four times the index
  localparam logic [3:0] IDX_CHAN_RATE = 4'h3;
  localparam logic [3:0] IDX_AMP_GAIN = 4'h4;
  localparam logic [3:0] IDX_SPARE = 4'h5;
  localparam logic [3:0] IDX_CHOP_DETECT = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'h7;

  // reset values
  localparam logic [15:0] RST_CHAN_RATE = 16'h0f0e;
  localparam logic [15:0] RST_AMP_GAIN = 16'h0000;
  localparam logic [15:0] RST_SPARE = 16'h0000;
  localparam logic [15:0] RST_CHOP_DETECT = 16'h0600;

  // writable bits; top nibble of channel config is read-only zero
  localparam logic [15:0] WMASK_CHAN_RATE = 16'h0fff;
  localparam logic [15:0] WMASK_FULL = 16'hffff;

  // channel config fields
  localparam int CH_ON_LSB = 8;
  localparam int OSR_LSB = 2;
  localparam int PWR_LSB = 0;

  // gain field positions, channel n at GAIN_LSB_STEP*n
  localparam int GAIN_LSB_STEP = 4;
  localparam int NUM_CH = 4;

  // status word: sticky flag for a nonzero write to the spare word
  localparam int ST_SPARE_NZ = 0;

  // ratio for the top oversampling code
  localparam logic [13:0] OSR_TOP_RATIO = 14'h3f80;
  localparam logic [13:0] OSR_BASE_RATIO = 14'h0080;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PM_VERY_LOW,
    PM_LOW,
    PM_HIGH_RES
  } power_mode_t;

  // decoded settings handed to the converter core
  typedef struct packed {
    logic [NUM_CH-1:0] channel_on;
    logic [13:0] oversampling_ratio;
    power_mode_t power_mode;
    logic [NUM_CH-1:0][7:0] amp_gain;
  } conv_ctrl_t;

endpackage

/* dv/adc_cfg_regs_checker.sv */
// concurrent checks on the configuration register bank ports
`timescale 1ns/1ns
`default_nettype none

module adc_cfg_regs_checker #(
  parameter int ADDR_W = 5
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  // read side
  input wire logic arvalid,
  input wire logic arready,
  // decoded outputs
  input wire adc_cfg_pkg::conv_ctrl_t conv_ctrl,
  input wire logic [15:0] chop_detect
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic wr_both;
  assign wr_both = awvalid && awready && wvalid && wready;

  // the first edge out of reset still shows the reset state
  a_rst_chan_on: assert property (
    $rose(aresetn) |-> conv_ctrl.channel_on == 4'hf)
    else $error("channel enables not all on after reset");
  a_rst_ratio: assert property (
    $rose(aresetn) |-> conv_ctrl.oversampling_ratio == 14'h0400)
    else $error("oversampling ratio not 1024 after reset");
  a_rst_power: assert property (
    $rose(aresetn) |-> conv_ctrl.power_mode == adc_cfg_pkg::PM_HIGH_RES)
    else $error("power mode not high resolution after reset");
  a_rst_unity_gain: assert property (
    $rose(aresetn) |-> conv_ctrl.amp_gain == 32'h01010101)
    else $error("gains not unity after reset");
  a_rst_chop_word: assert property (
    $rose(aresetn) |-> chop_detect == 16'h0600)
    else $error("chop word wrong after reset");
  a_ratio_legal: assert property (
    conv_ctrl.oversampling_ratio inside {14'h0080, 14'h0100, 14'h0200,
      14'h0400, 14'h0800, 14'h1000, 14'h2000, 14'h3f80})
    else $error("oversampling ratio outside its table");
  a_gain_power_two: assert property (
    $onehot(conv_ctrl.amp_gain[0]) && $onehot(conv_ctrl.amp_gain[1]) &&
    $onehot(conv_ctrl.amp_gain[2]) && $onehot(conv_ctrl.amp_gain[3]))
    else $error("a channel gain is not a power of two");
  a_write_chan_on: assert property (
    wr_both && awaddr == 5'h0c && wstrb[1] |=>
    conv_ctrl.channel_on == $past(wdata[11:8]))
    else $error("channel enables do not follow the write");
  a_write_gain_ch0: assert property (
    wr_both && awaddr == 5'h10 && wstrb[0] |=>
    conv_ctrl.amp_gain[0] == 8'h01 << $past(wdata[2:0]))
    else $error("channel 0 gain does not follow the write");

  c_write_done: cover property (bvalid && bready);
  c_read_taken: cover property (arvalid && arready);
  c_top_ratio: cover property (conv_ctrl.oversampling_ratio == 14'h3f80);
endmodule

bind adc_channel_gain_config_regs adc_cfg_regs_checker #(.ADDR_W(ADDR_W))
  u_chk (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
  .wdata, .wstrb, .bvalid, .bready, .arvalid, .arready, .conv_ctrl,
  .chop_detect);
`default_nettype wire

/* dv/adc_channel_gain_config_regs_tb_top.sv */
// register-level bench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none

module adc_channel_gain_config_regs_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  logic [15:0] chop_detect, d;
  adc_cfg_pkg::conv_ctrl_t conv_ctrl;
  int n_errors = 0;
  int cmp_count = 0;

  always #50 aclk = ~aclk;

  adc_channel_gain_config_regs DUT (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .conv_ctrl(conv_ctrl), .chop_detect(chop_detect));

  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // address and data offered together, each released when taken
  task wr(input logic [4:0] a, input logic [15:0] x);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0, x};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task rst_chk;
    rd(5'h0c);
    chk(v, 32'h0f0e);
    chk(32'(r), 32'h0);
    rd(5'h10);
    chk(v, 32'h0);
    rd(5'h14);
    chk(v, 32'h0);
    rd(5'h18);
    chk(v, 32'h0600);
    chk(32'(conv_ctrl.channel_on), 32'hf);
    chk(32'(conv_ctrl.oversampling_ratio), 32'd1024);
    chk(32'(conv_ctrl.power_mode), 32'h2);
    chk(32'(conv_ctrl.amp_gain), 32'h01010101);
    $display("test reset values done");
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rst_chk();
    // top nibble is written as ones to prove it stays zero
    for (int i = 0; i < 8; i++)
    begin
      d = {4'hf, 4'(i * 3), 3'h0, 3'(i), 2'(i)};
      wr(5'h0c, d);
      chk(32'(r), 32'h0);
      rd(5'h0c);
      chk(v, {20'h0, d[11:0]});
      chk(32'(conv_ctrl.channel_on), 32'(d[11:8]));
      chk(32'(conv_ctrl.oversampling_ratio),
        i == 7 ? 32'd16256 : 32'd128 << i);
      chk(32'(conv_ctrl.power_mode), i[1] ? 32'h2 : 32'(i[1:0]));
    end
    $display("test channel config done");
    for (int i = 0; i < 8; i++)
    begin
      d = {1'b0, 3'(i + 3), 1'b0, 3'(i + 2), 1'b0, 3'(i + 1), 1'b0, 3'(i)};
      wr(5'h10, d);
      rd(5'h10);
      chk(v, {16'h0, d});
      for (int n = 0; n < 4; n++)
        chk(32'(conv_ctrl.amp_gain[n]),
          32'h1 << ((i + n) % 8));
    end
    $display("test gain codes done");
    wr(5'h18, 16'h0a5c);
    chk(32'(chop_detect), 32'h0a5c);
    rd(5'h18);
    chk(v, 32'h0a5c);
    wr(5'h14, 16'h0000);
    rd(5'h14);
    chk(v, 32'h0);
    // only zeros went to the spare word, so the lapse flag stays clear
    rd(5'h1c);
    chk(v, 32'h0);
    chk(32'(r), 32'h0);
    // unmapped index answers with an error and no data
    wr(5'h00, 16'h1234);
    chk(32'(r), 32'h2);
    rd(5'h00);
    chk(v, 32'h0);
    chk(32'(r), 32'h2);
    $display("test chop, spare and unmapped done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rst_chk();
    summarize();
  end

  // 47 transfers of a few cycles each; generous margin
  initial
  begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
